// ---- swu_buf2.sv ----
// two entry skid buffer, valid and ready on both sides
// assumes source and sink on clk_sys
`timescale 1ns/1ps
module swu_buf2 #(
	parameter int W = 39
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic         ce,
	// filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	typedef struct packed {
		logic         ov;
		logic [W-1:0] od;
		logic         hv;
		logic [W-1:0] hd;
	} swu_buf_s;

	swu_buf_s r, n;

	always_comb begin
		n = r;
		if (!r.ov || out_ready) begin
			if (r.hv) begin
				n.ov = 1'b1;
				n.od = r.hd;
				n.hv = 1'b0;
				if (in_valid) begin
					n.hv = 1'b1;
					n.hd = in_data;
				end
			end else begin
				n.ov = in_valid;
				n.od = in_data;
			end
		end else if (in_valid && !r.hv) begin
			n.hv = 1'b1;
			n.hd = in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			r <= '0;
		end else if (ce) begin
			r <= n;
		end
	end

	assign in_ready  = !r.hv;
	assign out_valid = r.ov;
	assign out_data  = r.od;
endmodule : swu_buf2

// ---- swu_dev.sv ----
// slave end of the single wire uart link
// assumes the master keeps its own timing rules; user logic on clk_sys
`timescale 1ns/1ps
module swu_dev (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// link
	swu_if.dev               lnk,
	// address and reply setup
	input  wire logic [7:0]  node_address_setting,
	input  wire logic        address_increment_pin,
	input  wire logic [3:0]  reply_delay_setting,
	// accepted writes
	output logic             wr_valid,
	input  wire logic        wr_ready,
	output logic [6:0]       wr_reg,
	output logic [31:0]      wr_data,
	// read requests
	output logic             rd_req,
	output logic [6:0]       rd_reg,
	input  wire logic [31:0] rd_data,
	// status
	output logic [7:0]       dgram_count,
	output logic             rx_error
);
	import swu_pkg::*;

	typedef enum logic [2:0] {
		D_IDLE, D_SYNC, D_BITS, D_GAP, D_RECOV, D_TXWAIT, D_TXBITS, D_TXHOLD
	} swu_dst_e;

	typedef struct packed {
		swu_dst_e    st;
		logic        s1;
		logic        s2;
		logic        s3;
		logic        ln;
		logic        falls;
		logic [23:0] cnt;
		logic [23:0] gap;
		logic [15:0] bt;
		logic [15:0] bt_ok;
		logic [3:0]  bitn;
		logic [3:0]  bytn;
		logic [7:0]  shf;
		logic [7:0]  crc;
		logic [7:0]  node;
		logic [7:0]  rg;
		logic [31:0] data;
		logic [7:0]  dcnt;
		logic [9:0]  txf;
		logic [63:0] txd;
		logic        tx_o;
		logic        tx_oe;
		logic        rd_req;
		logic [6:0]  rd_reg;
		logic        err;
	} swu_dev_s;

	swu_dev_s r, n;

	logic        push;
	logic        buf_ready;
	logic        stable;
	logic        fall;
	logic        rise;
	logic [7:0]  own;
	logic [23:0] bt24;
	logic [23:0] gap_lim;
	logic [23:0] rec_lim;
	logic [3:0]  dly;
	logic [31:0] rdv;
	logic [55:0] hdr;
	logic [7:0]  tcrc;
	logic        last;

	// ----------------------------------------------------------------
	// line sampling and derived limits
	// ----------------------------------------------------------------
	assign stable  = (r.s2 == r.s3);
	assign fall    = stable && r.ln && !r.s3;
	assign rise    = stable && !r.ln && r.s3;
	assign own     = node_address_setting + {7'h00, address_increment_pin};
	assign bt24    = {8'h00, r.bt};
	assign gap_lim = {8'h00, r.bt_ok} * GAP_BITS;
	assign rec_lim = {8'h00, r.bt_ok} * RECOV_BITS;
	assign dly     = (reply_delay_setting == 4'h0) ? 4'h1 : reply_delay_setting;
	assign rdv     = (r.rg[6:0] == CNT_REG) ? {24'h000000, r.dcnt} : rd_data;
	assign hdr     = {SYNC_BYTE, MASTER_ADDR, 1'b0, r.rg[6:0], rdv};
	assign last    = (r.bytn == RD_BYTES && !r.rg[7]) || r.bytn == WR_BYTES;

	always_comb begin
		tcrc = 8'h00;
		for (int i = 6; i >= 0; i--) begin
			tcrc = swu_crc8(tcrc, hdr[i*8 +: 8]);
		end
	end

	// ----------------------------------------------------------------
	// receive and reply sequencing
	// ----------------------------------------------------------------
	always_comb begin
		n        = r;
		push     = 1'b0;
		n.s1     = lnk.line_true;
		n.s2     = r.s1;
		n.s3     = r.s2;
		n.rd_req = 1'b0;
		n.err    = 1'b0;
		if (stable) begin
			n.ln = r.s3;
		end
		if (r.gap != 24'hffffff) begin
			n.gap = r.gap + 24'h000001;
		end
		case (r.st)
			D_IDLE: begin
				if (fall) begin
					n.st    = D_SYNC;
					n.cnt   = 24'h000001; // the fall cycle counts as one
					n.gap   = '0;
					n.falls = 1'b0;
				end
			end
			D_SYNC: begin
				n.cnt = r.cnt + 24'h000001;
				if (rise && r.cnt < GLITCH_CLKS) begin
					n.st  = D_RECOV;
					n.cnt = '0;
					n.err = 1'b1;
				end else if (fall && !r.falls) begin
					n.falls = 1'b1;
				end else if (fall) begin
					n.bt   = r.cnt[17:2];
					n.st   = D_BITS;
					n.bitn = 4'h3;
					n.bytn = 4'h0;
					n.crc  = 8'h00;
					n.shf  = SYNC_BYTE;
					n.cnt  = {9'h000, r.cnt[17:3]};
					if (r.cnt[23:18] != 6'h00 || r.cnt[17:2] < MIN_BIT_CLKS) begin
						n.st  = D_RECOV;
						n.cnt = '0;
						n.err = 1'b1;
					end
				end
			end
			D_BITS: begin
				if (r.cnt != 24'h000000) begin
					n.cnt = r.cnt - 24'h000001;
				end else if (r.bitn != 4'h8) begin
					n.shf[r.bitn[2:0]] = r.ln;
					n.bitn             = r.bitn + 4'h1;
					n.cnt              = bt24 - 24'h000001;
				end else if (!r.ln) begin
					n.st  = D_RECOV;
					n.cnt = '0;
					n.err = 1'b1;
				end else begin
					n.st   = D_GAP;
					n.bytn = r.bytn + 4'h1;
					n.crc  = swu_crc8(r.crc, r.shf);
					if (r.bytn == 4'h1) begin
						n.node = r.shf;
					end else if (r.bytn == 4'h2) begin
						n.rg = r.shf;
					end else if (!last && r.bytn != 4'h0) begin
						n.data = {r.data[23:0], r.shf};
					end
					if (last) begin
						n.st = D_IDLE;
						if (r.shf != r.crc) begin
							n.st  = D_RECOV;
							n.cnt = '0;
							n.err = 1'b1;
						end else begin
							n.bt_ok = r.bt;
							if (r.node != own || own == MASTER_ADDR) begin
								n.st = D_IDLE;
							end else if (r.rg[7]) begin
								push = 1'b1;
								if (buf_ready) begin
									n.dcnt = r.dcnt + 8'h01;
								end
							end else begin
								n.st     = D_TXWAIT;
								n.rd_req = 1'b1;
								n.rd_reg = r.rg[6:0];
								n.cnt    = 24'(24'(dly) * REPLY_UNIT_BITS * bt24);
							end
						end
					end
				end
			end
			D_GAP: begin
				if (fall) begin
					n.st   = D_BITS;
					n.gap  = '0;
					n.bitn = 4'h0;
					n.cnt  = bt24 + {9'h000, r.bt[15:1]} - 24'h000001;
				end
			end
			D_RECOV: begin
				n.cnt = r.ln ? r.cnt + 24'h000001 : 24'h000000;
				if (r.ln && r.cnt >= rec_lim) begin
					n.st = D_IDLE;
				end
			end
			D_TXWAIT: begin
				if (r.cnt != 24'h000000) begin
					n.cnt = r.cnt - 24'h000001;
				end else begin
					n.st    = D_TXBITS;
					n.txd   = {hdr[47:0], tcrc, 8'h00};
					n.txf   = {1'b1, hdr[55:48], 1'b0};
					n.tx_o  = 1'b0;
					n.tx_oe = 1'b1;
					n.bitn  = 4'h0;
					n.bytn  = 4'h0;
					n.cnt   = bt24 - 24'h000001;
				end
			end
			D_TXBITS: begin
				if (r.cnt != 24'h000000) begin
					n.cnt = r.cnt - 24'h000001;
				end else if (r.bitn != 4'h9) begin
					n.txf  = {1'b1, r.txf[9:1]};
					n.tx_o = r.txf[1];
					n.bitn = r.bitn + 4'h1;
					n.cnt  = bt24 - 24'h000001;
				end else if (r.bytn == WR_BYTES) begin
					n.st  = D_TXHOLD;
					n.cnt = 24'(RELEASE_BITS * bt24) - 24'h000001;
				end else begin
					n.txf  = {1'b1, r.txd[63:56], 1'b0};
					n.txd  = {r.txd[55:0], 8'h00};
					n.tx_o = 1'b0;
					n.bitn = 4'h0;
					n.bytn = r.bytn + 4'h1;
					n.cnt  = bt24 - 24'h000001;
				end
			end
			D_TXHOLD: begin
				if (r.cnt != 24'h000000) begin
					n.cnt = r.cnt - 24'h000001;
				end else begin
					n.tx_oe = 1'b0;
					n.st    = D_IDLE;
				end
			end
			default: n.st = D_IDLE;
		endcase
		if ((r.st == D_SYNC || r.st == D_BITS || r.st == D_GAP)
			&& r.gap > gap_lim) begin
			n.st  = D_RECOV;
			n.cnt = '0;
			n.err = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			r       <= '0;
			r.st    <= D_IDLE;
			r.s1    <= 1'b1;
			r.s2    <= 1'b1;
			r.s3    <= 1'b1;
			r.ln    <= 1'b1;
			r.tx_o  <= 1'b1;
			r.bt    <= BT_INIT;
			r.bt_ok <= BT_INIT;
			r.dcnt  <= DCNT_RST;
		end else if (ce) begin
			r <= n;
		end
	end

	// ----------------------------------------------------------------
	// write buffer and outputs
	// ----------------------------------------------------------------
	swu_buf2 #(.W(39)) u_buf (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.ce        (ce),
		.in_valid  (push),
		.in_ready  (buf_ready),
		.in_data   ({r.rg[6:0], r.data}),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  ({wr_reg, wr_data})
	);

	assign lnk.dev_o   = r.tx_o;
	assign lnk.dev_oe  = r.tx_oe;
	assign rd_req      = r.rd_req;
	assign rd_reg      = r.rd_reg;
	assign dgram_count = r.dcnt;
	assign rx_error    = r.err;
endmodule : swu_dev

// ---- swu_host.sv ----
// master end of the single wire uart link, fixed baud
// assumes the slave keeps its own timing rules; user logic on clk_sys
`timescale 1ns/1ps
module swu_host (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// link
	swu_if.host              lnk,
	// command
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic        cmd_write,
	input  wire logic [7:0]  cmd_node,
	input  wire logic [6:0]  cmd_reg,
	input  wire logic [31:0] cmd_data,
	// response
	output logic             rsp_valid,
	output logic             rsp_ok,
	output logic [31:0]      rsp_data
);
	import swu_pkg::*;

	typedef enum logic [2:0] {
		H_QUIET, H_READY, H_TX, H_WAIT, H_RX, H_GAP
	} swu_hst_e;

	typedef struct packed {
		swu_hst_e    st;
		logic        s1;
		logic        s2;
		logic        s3;
		logic        ln;
		logic [23:0] cnt;
		logic [3:0]  bitn;
		logic [3:0]  bytn;
		logic [3:0]  nlast;
		logic [9:0]  txf;
		logic [63:0] txd;
		logic [7:0]  shf;
		logic [7:0]  crc;
		logic        nok;
		logic        wr;
		logic        tx_o;
		logic        tx_oe;
		logic        rdy;
		logic        rv;
		logic        rok;
		logic [31:0] rdat;
	} swu_hst_s;

	swu_hst_s r, n;

	logic        stable;
	logic        fall;
	logic [55:0] dg;
	logic [7:0]  c3;
	logic [7:0]  c7;

	assign stable = (r.s2 == r.s3);
	assign fall   = stable && r.ln && !r.s3;
	assign dg     = {SYNC_BYTE, cmd_node, cmd_write, cmd_reg, cmd_data};

	always_comb begin
		c3 = 8'h00;
		c7 = 8'h00;
		for (int i = 6; i >= 0; i--) begin
			c7 = swu_crc8(c7, dg[i*8 +: 8]);
			if (i >= 4) begin
				c3 = swu_crc8(c3, dg[i*8 +: 8]);
			end
		end
	end

	always_comb begin
		n    = r;
		n.s1 = lnk.line_true;
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.rv = 1'b0;
		if (stable) begin
			n.ln = r.s3;
		end
		case (r.st)
			H_QUIET: begin
				n.cnt = r.ln ? r.cnt + 24'h000001 : 24'h000000;
				if (r.ln && r.cnt >= RECOV_BITS * HOST_BIT_CLKS) begin
					n.st  = H_READY;
					n.rdy = 1'b1;
				end
			end
			H_READY: begin
				if (cmd_valid) begin
					n.rdy   = 1'b0;
					n.st    = H_TX;
					n.wr    = cmd_write;
					n.nlast = cmd_write ? WR_BYTES : RD_BYTES;
					n.txf   = {1'b1, SYNC_BYTE, 1'b0};
					n.txd   = cmd_write ? {dg[47:0], c7, 8'h00}
						: {dg[47:32], c3, 40'h0000000000};
					n.tx_o  = 1'b0;
					n.tx_oe = 1'b1;
					n.bitn  = 4'h0;
					n.bytn  = 4'h0;
					n.cnt   = HOST_BIT_CLKS - 24'h000001;
				end
			end
			H_TX: begin
				if (r.cnt != 24'h000000) begin
					n.cnt = r.cnt - 24'h000001;
				end else if (r.bitn != 4'h9) begin
					n.txf  = {1'b1, r.txf[9:1]};
					n.tx_o = r.txf[1];
					n.bitn = r.bitn + 4'h1;
					n.cnt  = HOST_BIT_CLKS - 24'h000001;
				end else if (r.bytn == r.nlast) begin
					n.tx_oe = 1'b0;
					n.cnt   = '0;
					n.st    = r.wr ? H_QUIET : H_WAIT;
					n.rv    = r.wr;
					n.rok   = 1'b1;
				end else begin
					n.txf  = {1'b1, r.txd[63:56], 1'b0};
					n.txd  = {r.txd[55:0], 8'h00};
					n.tx_o = 1'b0;
					n.bitn = 4'h0;
					n.bytn = r.bytn + 4'h1;
					n.cnt  = HOST_BIT_CLKS - 24'h000001;
				end
			end
			H_WAIT, H_GAP: begin
				n.cnt = r.cnt + 24'h000001;
				if (fall) begin
					n.st   = H_RX;
					n.bitn = 4'h0;
					n.cnt  = HOST_BIT_CLKS + {1'b0, HOST_BIT_CLKS[23:1]}
						- 24'h000001;
					if (r.st == H_WAIT) begin
						n.bytn = 4'h0;
						n.crc  = 8'h00;
						n.nok  = 1'b0;
					end
				end else if (r.cnt > (r.st == H_WAIT ? HOST_TMO_BITS : GAP_BITS)
					* HOST_BIT_CLKS) begin
					n.st  = H_QUIET;
					n.cnt = '0;
					n.rv  = 1'b1;
					n.rok = 1'b0;
				end
			end
			H_RX: begin
				if (r.cnt != 24'h000000) begin
					n.cnt = r.cnt - 24'h000001;
				end else if (r.bitn != 4'h8) begin
					n.shf[r.bitn[2:0]] = r.ln;
					n.bitn             = r.bitn + 4'h1;
					n.cnt              = HOST_BIT_CLKS - 24'h000001;
				end else begin
					n.st   = H_GAP;
					n.cnt  = '0;
					n.bytn = r.bytn + 4'h1;
					n.crc  = swu_crc8(r.crc, r.shf);
					if (r.bytn == 4'h1) begin
						n.nok = (r.shf == MASTER_ADDR);
					end else if (r.bytn >= 4'h3 && r.bytn < WR_BYTES) begin
						n.rdat = {r.rdat[23:0], r.shf};
					end
					if (r.bytn == WR_BYTES || !r.ln) begin
						n.st  = H_QUIET;
						n.rv  = 1'b1;
						n.rok = r.ln && r.nok && r.shf == r.crc;
					end
				end
			end
			default: n.st = H_QUIET;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			r      <= '0;
			r.st   <= H_QUIET;
			r.s1   <= 1'b1;
			r.s2   <= 1'b1;
			r.s3   <= 1'b1;
			r.ln   <= 1'b1;
			r.tx_o <= 1'b1;
		end else if (ce) begin
			r <= n;
		end
	end

	assign lnk.host_o  = r.tx_o;
	assign lnk.host_oe = r.tx_oe;
	assign cmd_ready   = r.rdy;
	assign rsp_valid   = r.rv;
	assign rsp_ok      = r.rok;
	assign rsp_data    = r.rdat;
endmodule : swu_host

// ---- swu_if.sv ----
// the single shared data line between master and slave
// assumes each end drives only while its enable is high
`timescale 1ns/1ps
interface swu_if;
	logic dev_o;
	logic dev_oe;
	logic host_o;
	logic host_oe;
	logic line_true;

	// pulled high when nobody drives
	assign line_true = dev_oe ? dev_o : (host_oe ? host_o : 1'b1);

	modport dev  (input line_true, output dev_o, output dev_oe);
	modport host (input line_true, output host_o, output host_oe);
endinterface : swu_if

// ---- swu_link_props.sv ----
// checker of the main link between the master and slave ends
// assumes the signals of one swu_if instance, sampled on clk_sys
`timescale 1ns/1ps
module swu_link_props (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// link
	input wire logic dev_o,
	input wire logic dev_oe,
	input wire logic host_o,
	input wire logic host_oe,
	input wire logic line_true
);
	import swu_pkg::*;
	localparam int B = int'(HOST_BIT_CLKS);
	logic [23:0] rh_r, rd_r, gap_r, hi_r;
	logic        hp_r, dp_r;

	// --------------------------------------------------------
	// run counters
	// --------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			{hp_r, dp_r}              <= 2'h3;
			{rh_r, rd_r, gap_r, hi_r} <= 96'h0;
		end else begin
			hp_r  <= host_o;
			dp_r  <= dev_o;
			rh_r  <= (host_o == hp_r) ? rh_r + 24'h1 : 24'h1;
			rd_r  <= (dev_o == dp_r) ? rd_r + 24'h1 : 24'h1;
			gap_r <= (host_oe || dev_oe) ? 24'h0 : gap_r + 24'h1;
			hi_r  <= line_true ? hi_r + 24'h1 : 24'h0;
		end
	end

	// --------------------------------------------------------
	// properties
	// --------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_one_driver;
		!(dev_oe && host_oe);
	endproperty
	a_one_driver: assert property (p_one_driver)
		else $error("both ends drive the line");
	property p_host_start;
		$rose(host_oe) |-> !host_o [*8];
	endproperty
	a_host_start: assert property (p_host_start)
		else $error("master frame without low start bit");
	property p_dev_start;
		$rose(dev_oe) |-> !dev_o [*8];
	endproperty
	a_dev_start: assert property (p_dev_start)
		else $error("reply without low start bit");
	property p_host_stop;
		$fell(host_oe) |-> $past(host_o) && rh_r >= B;
	endproperty
	a_host_stop: assert property (p_host_stop)
		else $error("master released before a full stop bit");
	property p_host_bit;
		host_oe && $past(host_oe) && host_o != hp_r |-> rh_r % B == 0;
	endproperty
	a_host_bit: assert property (p_host_bit)
		else $error("master bit length off");
	property p_dev_bit;
		dev_oe && $past(dev_oe) && dev_o != dp_r
			|-> (rd_r % B) <= 2 || (rd_r % B) >= B - 2;
	endproperty
	a_dev_bit: assert property (p_dev_bit)
		else $error("reply bit length differs from master");
	property p_reply_delay;
		$rose(dev_oe) |-> gap_r >= 7 * B && gap_r <= 9 * B;
	endproperty
	a_reply_delay: assert property (p_reply_delay)
		else $error("reply delay out of range");
	property p_dev_release;
		$fell(dev_oe) |-> $past(dev_o) && hi_r >= 5 * B - 8;
	endproperty
	a_dev_release: assert property (p_dev_release)
		else $error("slave released the line too early");

	c_host_frame: cover property ($rose(host_oe));
	c_reply: cover property ($rose(dev_oe));
	c_release: cover property ($fell(dev_oe));
endmodule : swu_link_props

// ---- swu_pkg.sv ----
// constants and the crc function of the single wire uart link
// assumes one system clock of 125 mhz shared by both ends
package swu_pkg;

	// --------------------------------------------------------------
	// framing and timing
	// --------------------------------------------------------------
	localparam int          CLK_HZ          = 125_000_000;
	localparam logic [7:0]  SYNC_BYTE       = 8'h05;
	localparam logic [7:0]  MASTER_ADDR     = 8'hff;
	localparam logic [7:0]  CRC_POLY        = 8'h07;
	localparam logic [23:0] GLITCH_CLKS     = 24'h000010;
	localparam logic [15:0] MIN_BIT_CLKS    = 16'h0010;
	localparam logic [23:0] GAP_BITS        = 24'h00003f;
	localparam logic [23:0] RECOV_BITS      = 24'h00000c;
	localparam logic [23:0] REPLY_UNIT_BITS = 24'h000008;
	localparam logic [23:0] RELEASE_BITS    = 24'h000004;
	localparam logic [15:0] BT_INIT         = 16'hffff;
	localparam logic [6:0]  CNT_REG         = 7'h02;
	localparam logic [7:0]  DCNT_RST        = 8'h00;
	localparam logic [3:0]  RD_BYTES        = 4'h3;
	localparam logic [3:0]  WR_BYTES        = 4'h7;

	// host side baud
	localparam int          HOST_BAUD       = 1_000_000;
	localparam logic [23:0] HOST_BIT_CLKS   = 24'(CLK_HZ / HOST_BAUD);
	localparam logic [23:0] HOST_TMO_BITS   = 24'h0000a0;

	// --------------------------------------------------------------
	// crc over one byte, lsb first
	// --------------------------------------------------------------
	function automatic logic [7:0] swu_crc8(input logic [7:0] crc,
		input logic [7:0] b);
		logic [7:0] c;
		c = crc;
		for (int i = 0; i < 8; i++) begin
			if (c[7] ^ b[i]) begin
				c = {c[6:0], 1'b0} ^ CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction : swu_crc8

endpackage : swu_pkg

// ---- swu_tb_top.sv ----
// testbench: master and slave on one link, a second slave on a driven link
// assumes swu_pkg, swu_if, swu_buf2, swu_dev, swu_host, swu_link_props
`timescale 1ns/1ps
module swu_tb_top;
	import swu_pkg::*;
	localparam int BT = 20; // one fixed bit time, never slowed
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	int          mismatches = 0;
	int          total_checks = 0;
	int          n_err = 0;
	int          cnt = 0;
	int          e = 0;
	int          w, wm;
	logic        cmd_valid, cmd_ready, cmd_write, rsp_valid, rsp_ok;
	logic        rsp_seen = 1'b0;
	logic        rsp_ok_c, rdreq_m, rdreq_b, wval_b, wrdy_b, inc_b, err_b;
	logic [3:0]  dly_m, dly_b;
	logic [6:0]  cmd_reg, rdreg_m, rdreg_b, wreg_b, rq_m, rq_b, r;
	logic [7:0]  cmd_node, cnt_m, cnt_b, node_b, b, c, eb;
	logic [31:0] cmd_data, rsp_data, rsp_dat_c, rdat_m, rdat_b, wdat_b;
	logic [31:0] d, ed;
	logic [38:0] exp_q [$];

	always #4 clk_sys = ~clk_sys;

	// --------------------------------------------------------
	// design
	// --------------------------------------------------------
	swu_if lnk_m ();
	swu_if lnk_b ();
	swu_host swu_host_inst (.clk_sys, .rst_n, .ce(1'b1),
		.lnk(lnk_m.host), .cmd_valid, .cmd_ready, .cmd_write, .cmd_node,
		.cmd_reg, .cmd_data, .rsp_valid, .rsp_ok, .rsp_data);
	swu_dev swu_dev_inst (.clk_sys, .rst_n, .ce(1'b1), .lnk(lnk_m.dev),
		.node_address_setting(cmd_node), .address_increment_pin(1'b0),
		.reply_delay_setting(dly_m), .wr_valid(), .wr_ready(1'b1),
		.wr_reg(), .wr_data(), .rd_req(rdreq_m), .rd_reg(rdreg_m),
		.rd_data(rdat_m), .dgram_count(cnt_m), .rx_error());
	swu_dev swu_dev_inst_b (.clk_sys, .rst_n, .ce(1'b1), .lnk(lnk_b.dev),
		.node_address_setting(node_b), .address_increment_pin(inc_b),
		.reply_delay_setting(dly_b), .wr_valid(wval_b), .wr_ready(wrdy_b),
		.wr_reg(wreg_b), .wr_data(wdat_b), .rd_req(rdreq_b),
		.rd_reg(rdreg_b), .rd_data(rdat_b), .dgram_count(cnt_b),
		.rx_error(err_b));
	swu_link_props swu_link_props_inst (.clk_sys, .rst_n,
		.dev_o(lnk_m.dev_o), .dev_oe(lnk_m.dev_oe), .host_o(lnk_m.host_o),
		.host_oe(lnk_m.host_oe), .line_true(lnk_m.line_true));

	// --------------------------------------------------------
	// tasks and monitors
	// --------------------------------------------------------
	task automatic check(input logic [63:0] seen, exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t %s", $time, what);
		end
	endtask : check

	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report

	function automatic logic [7:0] crc_step(input logic [7:0] q, v);
		for (int i = 0; i < 8; i++) begin
			q = (q[7] ^ v[i]) ? {q[6:0], 1'b0} ^ 8'h07 : {q[6:0], 1'b0};
		end
		return q;
	endfunction : crc_step

	task automatic put(input logic v, input int n);
		lnk_b.host_oe = 1'b1;
		lnk_b.host_o  = v;
		repeat (n) @(negedge clk_sys);
	endtask : put

	task automatic dgram(input logic [7:0] nd, rr, input logic [31:0] dd,
		input int len, cut, input logic bad, input int idle);
		logic [7:0] cc, bb;
		cc = 8'h00;
		for (int k = 0; k < cut; k++) begin
			case (k)
				0: bb = 8'h05;
				1: bb = nd;
				2: bb = rr;
				default: bb = dd[8 * (6 - k) +: 8];
			endcase
			if (k == len - 1) bb = cc ^ {7'h00, bad};
			cc = crc_step(cc, bb);
			put(1'b0, BT);
			for (int i = 0; i < 8; i++) put(bb[i], BT);
			put(1'b1, BT);
		end
		lnk_b.host_oe = 1'b0;
		repeat (idle * BT) @(negedge clk_sys);
	endtask : dgram

	task automatic get(output logic [7:0] v, output int n);
		n = 0;
		while (lnk_b.line_true !== 1'b0 && n < 2000) begin
			@(negedge clk_sys);
			n++;
		end
		repeat (BT + BT / 2) @(negedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			v[i] = lnk_b.line_true;
			repeat (BT) @(negedge clk_sys);
		end
	endtask : get

	always @(posedge clk_sys) begin
		if (rdreq_m === 1'b1) rq_m <= rdreg_m;
		if (rdreq_b === 1'b1) rq_b <= rdreg_b;
		if (err_b === 1'b1) n_err <= n_err + 1;
		if (rsp_valid === 1'b1) begin
			rsp_seen  <= 1'b1;
			rsp_ok_c  <= rsp_ok;
			rsp_dat_c <= rsp_data;
		end
		if (wval_b === 1'b1 && wrdy_b === 1'b1) begin
			check({wreg_b, wdat_b}, exp_q.size() ? exp_q.pop_front() : 'x,
				"written word");
		end
	end

	initial begin
		repeat (60000) @(posedge clk_sys);
		mismatches++;
		final_report();
	end

	// --------------------------------------------------------
	// sequence
	// --------------------------------------------------------
	initial begin
		void'($urandom(3));
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_node  = 8'($urandom_range(253));
		cmd_reg   = {2'b01, 5'($urandom)};
		cmd_data  = $urandom;
		rdat_m    = $urandom;
		rdat_b    = $urandom;
		node_b    = 8'($urandom_range(252));
		{dly_m, dly_b} = 8'h02;
		{wrdy_b, inc_b} = 2'h2;
		lnk_b.host_oe = 1'b0;
		lnk_b.host_o  = 1'b1;
		repeat (4) @(negedge clk_sys);
		rst_n = 1'b1;
		fork
			begin
				wm = 0;
				while (cmd_ready !== 1'b1 && wm < 20000) begin
					@(negedge clk_sys);
					wm++;
				end
				cmd_valid = 1'b1;
				@(posedge clk_sys);
				@(negedge clk_sys);
				cmd_valid = 1'b0;
				while (rsp_seen !== 1'b1 && wm < 200000) begin
					@(negedge clk_sys);
					wm++;
				end
				check(rsp_ok_c, 1'b1, "reply ok");
				check(rsp_dat_c, rdat_m, "read data");
				check(rq_m, cmd_reg, "read register");
				check(cnt_m, 8'h00, "count after read");
			end
			begin
				for (int k = 0; k < 5; k++) begin
					inc_b = (k == 4);
					d = $urandom;
					r = 7'($urandom);
					if (k == 0 || k == 4) exp_q.push_back({r, d});
					dgram(node_b + 8'(k == 1 || k == 4), {1'b1, r}, d, 8,
						(k == 3) ? 2 : 8, k == 2, 14);
					if (k == 3) repeat (80 * BT) @(negedge clk_sys);
					cnt += (k == 0 || k == 4);
					e += (k == 2 || k == 3);
					check(cnt_b, cnt, "write count");
					check(n_err, e, "error count");
				end
				put(1'b0, 5);
				lnk_b.host_oe = 1'b0;
				repeat (14 * BT) @(negedge clk_sys);
				check(n_err, e + 1, "glitch");
				wrdy_b = 1'b0;
				for (int k = 0; k < 3; k++) begin
					d = $urandom;
					r = 7'($urandom);
					if (k < 2) exp_q.push_back({r, d});
					dgram(node_b + 8'h01, {1'b1, r}, d, 8, 8, 1'b0, 14);
				end
				cnt += 2;
				check(cnt_b, cnt, "count, buffer full");
				check(exp_q.size(), 2, "words held");
				wrdy_b = 1'b1;
				repeat (8) @(negedge clk_sys);
				check(exp_q.size(), 0, "buffer drained");
				for (int k = 0; k < 2; k++) begin
					r = k ? CNT_REG : 7'h11;
					ed = k ? 32'(cnt) : rdat_b;
					dgram(node_b + 8'h01, {1'b0, r}, 32'h0, 4, 4, 1'b0, 0);
					c = 8'h00;
					for (int j = 0; j < 8; j++) begin
						get(b, w);
						if (j == 0) check(w >= 15 * BT && w <= 17 * BT, 1'b1,
							"reply delay");
						eb = (j == 0) ? 8'h05 : (j == 1) ? 8'hff :
							(j == 2) ? {1'b0, r} : (j == 7) ? c :
							ed[8 * (6 - j) +: 8];
						check(b, eb, "reply byte");
						c = crc_step(c, b);
					end
					if (k == 0) check(rq_b, 7'h11, "read request");
					repeat (20 * BT) @(negedge clk_sys);
					check(cnt_b, cnt, "count after read");
				end
			end
		join
		final_report();
	end
endmodule : swu_tb_top
